//--- common/dcd_regs.vh
`ifndef DCD_REGS_VH
`define DCD_REGS_VH

// Register offsets in CPU I/O space
`define DCD_OFS_STATUS 8'h30
`define DCD_OFS_CH0_MODE 8'h31
`define DCD_OFS_WAIT_CTL 8'h32

// Status/enable register fields
`define DCD_ST_CH1_EN 7
`define DCD_ST_CH0_EN 6
`define DCD_ST_CH1_GUARD 5
`define DCD_ST_CH0_GUARD 4
`define DCD_ST_CH1_IRQ_EN 3
`define DCD_ST_CH0_IRQ_EN 2
`define DCD_ST_MAIN_EN 0

// Channel 0 mode register fields
`define DCD_MD_DEST_HI 5
`define DCD_MD_DEST_LO 4
`define DCD_MD_SRC_HI 3
`define DCD_MD_SRC_LO 2
`define DCD_MD_BURST 1

// Wait control register fields
`define DCD_WC_MEM_HI 7
`define DCD_WC_MEM_LO 6
`define DCD_WC_IO_HI 5
`define DCD_WC_IO_LO 4
`define DCD_WC_SENSE0 3
`define DCD_WC_SENSE1 2
`define DCD_WC_DIR_HI 1
`define DCD_WC_DIR_LO 0

// Reset values
`define DCD_RST_STATUS_BITS 1'b0
`define DCD_RST_CH0_MODE 8'h00
`define DCD_RST_WAIT_CTL 8'hF0

// Address step codes shared by the mode fields
`define DCD_STEP_INC 2'h0
`define DCD_STEP_DEC 2'h1
`define DCD_STEP_FIX 2'h2
`define DCD_STEP_IO 2'h3

// Request select codes
`define DCD_REQ_PIN 3'h0
`define DCD_REQ_SER0 3'h1
`define DCD_REQ_SER1 3'h2

// Timing counts in clocks
`define DCD_MEM_CYCLE_CLK 3'h3
`define DCD_IO_CYCLE_CLK 3'h3
`define DCD_CPU_CYCLE_CLK 3'h3

`endif

//--- rtl/dcd_dma_ctrl.v
// Functional notes
// - A channel transfers only while its enable bit and the main enable are both set.
// - Byte count reaching zero ends the transfer and hardware clears that channel enable.
// - Channel enable low with its interrupt enable high raises a DMA interrupt request.
// - A write alters a channel enable only when its guard bit is written as zero.
// - Both guard bit positions always read back as one.
// - Writing one to a channel enable also sets main enable; zero stops it, restartable.
// - Main enable is not writable; a non-maskable interrupt clears it.
// - Reset clears both channel enables, both interrupt enables and main enable.
// - Channel 0 destination mode: increment, decrement, fixed memory, fixed I/O; resets 00.
// - Channel 0 source mode uses the same four codes.
// - For memory to memory, burst select one gives burst, zero cycle steal; resets zero.
// - Burst holds the bus to count zero; cycle steal gives CPU one cycle per byte.
// - With an I/O side, channel 0 is paced by its request and ignores burst select.
// - Memory wait field adds 0 to 3 waits to memory cycles; resets to 11.
// - I/O wait field adds 1 to 4 waits to the 3-clock I/O cycle; resets 11.
// - Sense bits: upper for channel 0, lower for channel 1; 0 level, 1 edge.
// - Channel 1 mode picks direction and memory step; the I/O address stays fixed.
// - Channel 1 I/O destination request: pin, serial 0 or serial 1 transmit-empty.
// - Channel 1 I/O source request: pin, serial 0 or serial 1 receive-full.
// - Each byte decrements the count; zero terminates; software loads the count first.
`timescale 1ns/1ps
`include "dcd_regs.vh"
module dcd_dma_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // CPU I/O register port
  input wire [7:0] IO_ADDR,
  input wire IO_WR,
  input wire IO_RD,
  input wire [7:0] IO_WDATA,
  output reg [7:0] IO_RDATA,
  // Byte count loading and request source selection
  input wire CH0_COUNT_LOAD,
  input wire [15:0] CH0_COUNT_IN,
  input wire CH1_COUNT_LOAD,
  input wire [15:0] CH1_COUNT_IN,
  input wire [1:0] CH0_REQ_SEL,
  input wire [2:0] CH1_REQ_SEL,
  // Request sources and NMI: pins from outside, serial flags on-chip
  input wire NMI_N,
  input wire CH0_REQUEST_PIN_N,
  input wire CHAN1_REQUEST_PIN_N,
  input wire SER0_TRANSMIT_EMPTY_FLAG,
  input wire SER0_RECEIVE_FULL_FLAG,
  input wire SER1_TRANSMIT_EMPTY_FLAG,
  input wire SER1_RECEIVE_FULL_FLAG,
  // System bus cycle control
  output wire BUS_HOLD,
  output wire BUS_RD,
  output wire BUS_WR,
  output wire BUS_IO,
  output wire BUS_CH,
  output wire [1:0] BUS_STEP,
  output wire BUS_DONE,
  input wire [7:0] BUS_RDATA,
  output wire [7:0] BUS_WDATA,
  // Shared wait-state settings and status
  output wire [1:0] MEM_WAIT_STATES,
  output wire [2:0] IO_WAIT_STATES,
  output wire [15:0] CH0_COUNT,
  output wire [15:0] CH1_COUNT,
  output wire DMA_IRQ
);
  localparam S_IDLE = 2'b00;
  localparam S_RD = 2'b01;
  localparam S_WR = 2'b10;
  localparam S_GAP = 2'b11;
  localparam [2:0] MEM_BASE = `DCD_MEM_CYCLE_CLK - 3'h1;
  localparam [2:0] IO_BASE = `DCD_IO_CYCLE_CLK - 3'h1;
  localparam [2:0] GAP_LEN = `DCD_CPU_CYCLE_CLK - 3'h1;

  reg ch1_enable_r;
  reg chan0_enable_r;
  reg chan1_irq_enable_r;
  reg chan0_irq_enable_r;
  reg main_transfer_enable_r;
  reg [7:0] mode_r;
  reg [7:0] wctl_r;
  reg [15:0] cnt0_r;
  reg [15:0] cnt1_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] tick_r;
  reg ch_r;
  reg [2:0] sync0_r;
  reg [2:0] sync1_r;
  reg [2:0] nmi_sync_r;
  reg raw0_q_r;
  reg raw1_q_r;
  reg edge0_r;
  reg edge1_r;

  wire wr_status = IO_WR & (IO_ADDR == `DCD_OFS_STATUS);
  wire nmi_event = nmi_sync_r[2] & ~nmi_sync_r[1];
  wire [1:0] chan0_dest_mode = mode_r[`DCD_MD_DEST_HI:`DCD_MD_DEST_LO];
  wire [1:0] chan0_src_mode = mode_r[`DCD_MD_SRC_HI:`DCD_MD_SRC_LO];
  wire burst_select = mode_r[`DCD_MD_BURST];
  wire [1:0] memory_wait_count = wctl_r[`DCD_WC_MEM_HI:`DCD_WC_MEM_LO];
  wire [1:0] io_wait_count = wctl_r[`DCD_WC_IO_HI:`DCD_WC_IO_LO];
  wire [1:0] chan1_direction_mode = wctl_r[`DCD_WC_DIR_HI:`DCD_WC_DIR_LO];

  // Channel 0 is paced only when one side is I/O
  wire src0_io = (chan0_src_mode == `DCD_STEP_IO);
  wire dst0_io = (chan0_dest_mode == `DCD_STEP_IO);
  wire ch0_paced = src0_io | dst0_io;
  wire ch0_memmem = ~ch0_paced;

  // Request source selection; reserved codes never request
  reg raw0;
  reg raw1;
  always @*
  begin
    case (CH0_REQ_SEL)
      2'h0: raw0 = sync0_r[2];
      2'h1: raw0 = src0_io ? SER0_RECEIVE_FULL_FLAG : SER0_TRANSMIT_EMPTY_FLAG;
      2'h2: raw0 = src0_io ? SER1_RECEIVE_FULL_FLAG : SER1_TRANSMIT_EMPTY_FLAG;
      default: raw0 = 1'b0;
    endcase
    case (CH1_REQ_SEL)
      `DCD_REQ_PIN: raw1 = sync1_r[2];
      `DCD_REQ_SER0: raw1 = chan1_direction_mode[1] ? SER0_RECEIVE_FULL_FLAG : SER0_TRANSMIT_EMPTY_FLAG;
      `DCD_REQ_SER1: raw1 = chan1_direction_mode[1] ? SER1_RECEIVE_FULL_FLAG : SER1_TRANSMIT_EMPTY_FLAG;
      default: raw1 = 1'b0;
    endcase
  end

  // Level sense uses the raw request, edge sense a latched rising edge
  wire req0 = wctl_r[`DCD_WC_SENSE0] ? edge0_r : raw0;
  wire req1 = wctl_r[`DCD_WC_SENSE1] ? edge1_r : raw1;

  // Channel readiness, channel 0 first in priority
  wire run0 = chan0_enable_r & main_transfer_enable_r;
  wire run1 = ch1_enable_r & main_transfer_enable_r;
  wire go0 = run0 & (cnt0_r != 16'h0000) & (ch0_memmem | req0);
  wire go1 = run1 & (cnt1_r != 16'h0000) & req1;

  // Side attributes of the active channel
  wire rd_io = ch_r ? chan1_direction_mode[1] : src0_io;
  wire wr_io = ch_r ? ~chan1_direction_mode[1] : dst0_io;
  wire [1:0] ch1_mem_step = chan1_direction_mode[0] ? `DCD_STEP_DEC : `DCD_STEP_INC;
  wire [1:0] rd_step = ch_r ? (chan1_direction_mode[1] ? `DCD_STEP_IO : ch1_mem_step) : chan0_src_mode;
  wire [1:0] wr_step = ch_r ? (chan1_direction_mode[1] ? ch1_mem_step : `DCD_STEP_IO) : chan0_dest_mode;
  wire cur_io = (state_r == S_WR) ? wr_io : rd_io;

  // Cycle length: base clocks plus the programmed waits
  wire [2:0] mem_len = MEM_BASE + {1'b0, memory_wait_count};
  wire [2:0] io_len = IO_BASE + {1'b0, io_wait_count} + 3'h1;
  wire [2:0] rd_len = rd_io ? io_len : mem_len;
  wire [2:0] wr_len = wr_io ? io_len : mem_len;

  // Bytes pass through the FIFO between the read and write cycles
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire rd_end = (state_r == S_RD) & (tick_r == 3'h0) & fifo_in_ready;
  wire wr_end = (state_r == S_WR) & (tick_r == 3'h0) & fifo_out_valid;
  wire [15:0] cur_cnt = ch_r ? cnt1_r : cnt0_r;
  wire last_byte = (cur_cnt == 16'h0001);
  wire start0 = (state_r == S_IDLE) & go0;
  wire start1 = (state_r == S_IDLE) & ~go0 & go1;
  wire burst_on = ~ch_r & ch0_memmem & burst_select;

  dcd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(rd_end),
    .in_ready(fifo_in_ready),
    .in_data(BUS_RDATA),
    .out_valid(fifo_out_valid),
    .out_ready(wr_end),
    .out_data(BUS_WDATA)
  );

  // Transfer sequencer
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (go0 | go1)
          state_nxt = S_RD;
      S_RD:
        if (rd_end)
          state_nxt = S_WR;
      S_WR:
        if (wr_end)
        begin
          if (last_byte | ~run0 | ch_r | ch0_paced)
            state_nxt = S_IDLE;
          else if (burst_on)
            state_nxt = S_RD;
          else
            state_nxt = S_GAP;
        end
      S_GAP:
        if (tick_r == 3'h0)
          state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // Sequencer registers and cycle timer
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= S_IDLE;
      tick_r <= 3'h0;
      ch_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (start0 | start1)
      begin
        ch_r <= start1;
        tick_r <= start1 ? (chan1_direction_mode[1] ? io_len : mem_len) : (src0_io ? io_len : mem_len);
      end
      else if (rd_end)
        tick_r <= wr_len;
      else if (wr_end)
        tick_r <= (state_nxt == S_RD) ? rd_len : GAP_LEN;
      else if (tick_r != 3'h0)
        tick_r <= tick_r - 3'h1;
    end
  end

  // Synchronisers for the pins; first stage feeds only the second
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync0_r <= 3'h0;
      sync1_r <= 3'h0;
      nmi_sync_r <= 3'h7;
    end
    else
    begin
      sync0_r <= {sync0_r[1:0], ~CH0_REQUEST_PIN_N};
      sync1_r <= {sync1_r[1:0], ~CHAN1_REQUEST_PIN_N};
      nmi_sync_r <= {nmi_sync_r[1:0], NMI_N};
    end
  end

  // Edge latches: a new edge wins over the clear at transfer start; level sense keeps them
  // empty, so an edge seen while level sensing cannot start a transfer after a mode change
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      raw0_q_r <= 1'b0;
      raw1_q_r <= 1'b0;
      edge0_r <= 1'b0;
      edge1_r <= 1'b0;
    end
    else
    begin
      raw0_q_r <= raw0;
      raw1_q_r <= raw1;
      edge0_r <= wctl_r[`DCD_WC_SENSE0] & ((raw0 & ~raw0_q_r) | (edge0_r & ~start0));
      edge1_r <= wctl_r[`DCD_WC_SENSE1] & ((raw1 & ~raw1_q_r) | (edge1_r & ~start1));
    end
  end

  // Byte counters, decremented once per completed byte
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cnt0_r <= 16'h0000;
      cnt1_r <= 16'h0000;
    end
    else
    begin
      if (CH0_COUNT_LOAD)
        cnt0_r <= CH0_COUNT_IN;
      else if (wr_end & ~ch_r)
        cnt0_r <= cnt0_r - 16'h0001;
      if (CH1_COUNT_LOAD)
        cnt1_r <= CH1_COUNT_IN;
      else if (wr_end & ch_r)
        cnt1_r <= cnt1_r - 16'h0001;
    end
  end

  // Status/enable bits; a software write with the guard bit zero wins over hardware termination
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ch1_enable_r <= `DCD_RST_STATUS_BITS;
      chan0_enable_r <= `DCD_RST_STATUS_BITS;
      chan1_irq_enable_r <= `DCD_RST_STATUS_BITS;
      chan0_irq_enable_r <= `DCD_RST_STATUS_BITS;
      main_transfer_enable_r <= `DCD_RST_STATUS_BITS;
    end
    else
    begin
      if (wr_status & ~IO_WDATA[`DCD_ST_CH1_GUARD])
        ch1_enable_r <= IO_WDATA[`DCD_ST_CH1_EN];
      else if (run1 & (cnt1_r == 16'h0000 | (wr_end & ch_r & last_byte)))
        ch1_enable_r <= 1'b0;
      if (wr_status & ~IO_WDATA[`DCD_ST_CH0_GUARD])
        chan0_enable_r <= IO_WDATA[`DCD_ST_CH0_EN];
      else if (run0 & (cnt0_r == 16'h0000 | (wr_end & ~ch_r & last_byte)))
        chan0_enable_r <= 1'b0;
      if (wr_status)
      begin
        chan1_irq_enable_r <= IO_WDATA[`DCD_ST_CH1_IRQ_EN];
        chan0_irq_enable_r <= IO_WDATA[`DCD_ST_CH0_IRQ_EN];
      end
      // NMI halts DMA even against a restarting write in the same cycle
      if (nmi_event)
        main_transfer_enable_r <= 1'b0;
      else if (wr_status & ((~IO_WDATA[`DCD_ST_CH1_GUARD] & IO_WDATA[`DCD_ST_CH1_EN]) |
                            (~IO_WDATA[`DCD_ST_CH0_GUARD] & IO_WDATA[`DCD_ST_CH0_EN])))
        main_transfer_enable_r <= 1'b1;
    end
  end

  // Mode and wait control registers
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_r <= `DCD_RST_CH0_MODE;
      wctl_r <= `DCD_RST_WAIT_CTL;
    end
    else
    begin
      if (IO_WR & (IO_ADDR == `DCD_OFS_CH0_MODE))
        mode_r <= {2'b00, IO_WDATA[5:1], 1'b0};
      if (IO_WR & (IO_ADDR == `DCD_OFS_WAIT_CTL))
        wctl_r <= IO_WDATA;
    end
  end

  // Registered read data; unmapped addresses read zero
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
      IO_RDATA <= 8'h00;
    else if (IO_RD)
    begin
      case (IO_ADDR)
        `DCD_OFS_STATUS: IO_RDATA <= {ch1_enable_r, chan0_enable_r, 2'b11, chan1_irq_enable_r,
                                      chan0_irq_enable_r, 1'b0, main_transfer_enable_r};
        `DCD_OFS_CH0_MODE: IO_RDATA <= mode_r;
        `DCD_OFS_WAIT_CTL: IO_RDATA <= wctl_r;
        default: IO_RDATA <= 8'h00;
      endcase
    end
  end

  // Bus side outputs; the gap state hands the bus to the CPU
  assign BUS_HOLD = (state_r == S_RD) | (state_r == S_WR);
  assign BUS_RD = (state_r == S_RD);
  assign BUS_WR = (state_r == S_WR);
  assign BUS_IO = BUS_HOLD & cur_io;
  assign BUS_CH = ch_r;
  assign BUS_STEP = (state_r == S_WR) ? wr_step : rd_step;
  assign BUS_DONE = rd_end | wr_end;
  assign MEM_WAIT_STATES = memory_wait_count;
  assign IO_WAIT_STATES = {1'b0, io_wait_count} + 3'h1;
  assign CH0_COUNT = cnt0_r;
  assign CH1_COUNT = cnt1_r;
  // Termination requests stay up while the condition holds
  assign DMA_IRQ = (~ch1_enable_r & chan1_irq_enable_r) | (~chan0_enable_r & chan0_irq_enable_r);
endmodule

//--- rtl/dcd_fifo.v
`timescale 1ns/1ps
module dcd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] level_r;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign in_ready = (level_r != DEPTH[AW:0]);
  assign out_valid = (level_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only pointers and count need a known start
  always @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      level_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push & ~pop)
        level_r <= level_r + 1'b1;
      else if (pop & ~push)
        level_r <= level_r - 1'b1;
    end
  end
endmodule

//--- test/dcd_bus_partner.sv
`timescale 1ns/1ps
module dcd_bus_partner (
  // Bus cycle
  input wire clk,
  input wire bus_rd,
  input wire bus_wr,
  input wire bus_done,
  input wire [7:0] bus_wdata,
  output wire [7:0] bus_rdata,
  // Request handshake
  input wire serve,
  output wire req_pin_n,
  // Scoreboard
  output reg [7:0] wr_count,
  output reg [7:0] bad
);
  reg [7:0] rd_count = 8'h00;
  reg [7:0] last = 8'h00;
  initial wr_count = 8'h00;
  initial bad = 8'h00;
  // Running pattern so a lost or doubled byte shows; outside reads the lines carry no stale value
  assign bus_rdata = bus_rd ? 8'hA0 + rd_count : ~last;
  // Level request held while the peripheral wants service
  assign req_pin_n = ~serve;
  always @(posedge clk)
  begin
    if (bus_done && bus_rd)
    begin
      last <= bus_rdata;
      rd_count <= rd_count + 8'h01;
    end
    if (bus_done && bus_wr)
    begin
      if (bus_wdata !== 8'hA0 + wr_count)
        bad <= bad + 8'h01;
      wr_count <= wr_count + 8'h01;
    end
  end
endmodule

//--- test/dcd_dma_ctrl_properties.sv
`timescale 1ns/1ps
module dcd_dma_ctrl_properties (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Register port
  input wire [7:0] IO_ADDR,
  input wire IO_WR,
  input wire IO_RD,
  input wire [7:0] IO_WDATA,
  input wire [7:0] IO_RDATA,
  // Bus cycles and status
  input wire CH0_COUNT_LOAD,
  input wire BUS_HOLD,
  input wire BUS_RD,
  input wire BUS_WR,
  input wire BUS_IO,
  input wire BUS_CH,
  input wire [1:0] BUS_STEP,
  input wire BUS_DONE,
  input wire [15:0] CH0_COUNT,
  input wire [1:0] MEM_WAIT_STATES,
  input wire [2:0] IO_WAIT_STATES,
  input wire DMA_IRQ
);
  reg [3:0] ph_cnt_r;
  wire st_wr = IO_WR && IO_ADDR == 8'h30;
  // Clocks spent in the current phase; a cycle-steal gap restarts it
  always @(posedge CLK or posedge RST)
    if (RST)
      ph_cnt_r <= 4'h0;
    else
      ph_cnt_r <= (BUS_DONE || !BUS_HOLD) ? 4'h0 : ph_cnt_r + 4'h1;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_guard_reads_one: assert property (
    $past(IO_RD) && $past(IO_ADDR) == 8'h30 |-> IO_RDATA[5:4] == 2'h3) else $error("guard bits read low");
  a_mem_wait_code: assert property (
    IO_WR && IO_ADDR == 8'h32 |=> {6'h00, MEM_WAIT_STATES} == $past(IO_WDATA) >> 6) else $error("memory wait wrong");
  a_io_wait_code: assert property (
    IO_WR && IO_ADDR == 8'h32 |=> {5'h00, IO_WAIT_STATES} == (($past(IO_WDATA) >> 4) & 8'h03) + 8'h01)
    else $error("io wait wrong");
  a_mem_phase_len: assert property (
    BUS_DONE && !BUS_IO |-> ph_cnt_r == 4'h2 + MEM_WAIT_STATES) else $error("memory phase length wrong");
  a_io_phase_len: assert property (
    BUS_DONE && BUS_IO |-> ph_cnt_r == 4'h2 + IO_WAIT_STATES) else $error("io phase length wrong");
  a_ch1_io_fixed: assert property (
    BUS_HOLD && BUS_CH && BUS_IO |-> BUS_STEP == 2'h3) else $error("channel 1 port address not fixed");
  a_read_then_write: assert property (
    $rose(BUS_WR) |-> $past(BUS_RD)) else $error("write phase without read phase");
  a_irq_on_stop: assert property (
    st_wr && !IO_WDATA[4] && !IO_WDATA[6] && IO_WDATA[2] |=> DMA_IRQ) else $error("irq missing");
  a_irq_off_start: assert property (
    st_wr && IO_WDATA[7:4] == 4'hC |=> !DMA_IRQ) else $error("irq while enabled");
  a_count_by_one: assert property (
    $changed(CH0_COUNT) && !$past(CH0_COUNT_LOAD) |-> CH0_COUNT == $past(CH0_COUNT) - 16'h0001)
    else $error("count step wrong");
  c_io_phase: cover property (BUS_DONE && BUS_IO);
  c_steal_gap: cover property (BUS_HOLD ##1 !BUS_HOLD [*3] ##1 !BUS_HOLD);
  c_irq: cover property ($rose(DMA_IRQ));
endmodule
bind dcd_dma_ctrl dcd_dma_ctrl_properties u_dcd_dma_ctrl_properties (.CLK(CLK), .RST(RST), .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .CH0_COUNT_LOAD(CH0_COUNT_LOAD),
  .BUS_HOLD(BUS_HOLD), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_IO(BUS_IO), .BUS_CH(BUS_CH),
  .BUS_STEP(BUS_STEP), .BUS_DONE(BUS_DONE),
  .CH0_COUNT(CH0_COUNT), .MEM_WAIT_STATES(MEM_WAIT_STATES), .IO_WAIT_STATES(IO_WAIT_STATES), .DMA_IRQ(DMA_IRQ));

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg CLK = 0, RST = 1, IO_WR = 0, IO_RD = 0, NMI_N = 1, CH0_COUNT_LOAD = 0, CH1_COUNT_LOAD = 0;
  reg [7:0] IO_ADDR = 8'h00, IO_WDATA = 8'h00;
  reg [15:0] CH0_COUNT_IN = 16'h0000, CH1_COUNT_IN = 16'h0000, keep;
  reg [1:0] CH0_REQ_SEL = 2'h3;
  reg [2:0] CH1_REQ_SEL = 3'h0;
  reg [4:0] req = 5'h00;
  wire [7:0] IO_RDATA, BUS_RDATA, BUS_WDATA, wr_count, bad;
  wire [15:0] CH0_COUNT, CH1_COUNT;
  wire [1:0] BUS_STEP, MEM_WAIT_STATES;
  wire [2:0] IO_WAIT_STATES;
  wire BUS_HOLD, BUS_RD, BUS_WR, BUS_IO, BUS_CH, BUS_DONE, DMA_IRQ, pin_n;
  integer failures = 0, checks = 0, falls, i;
  always #5 CLK = ~CLK;
  dcd_dma_ctrl u_dcd_dma_ctrl (.CLK(CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .CH0_COUNT_LOAD(CH0_COUNT_LOAD), .CH0_COUNT_IN(CH0_COUNT_IN),
    .CH1_COUNT_LOAD(CH1_COUNT_LOAD), .CH1_COUNT_IN(CH1_COUNT_IN), .CH0_REQ_SEL(CH0_REQ_SEL),
    .CH1_REQ_SEL(CH1_REQ_SEL), .NMI_N(NMI_N), .CH0_REQUEST_PIN_N(pin_n), .CHAN1_REQUEST_PIN_N(pin_n),
    .SER0_TRANSMIT_EMPTY_FLAG(req[1]), .SER0_RECEIVE_FULL_FLAG(req[2]), .SER1_TRANSMIT_EMPTY_FLAG(req[3]),
    .SER1_RECEIVE_FULL_FLAG(req[4]), .BUS_HOLD(BUS_HOLD), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_IO(BUS_IO),
    .BUS_CH(BUS_CH), .BUS_STEP(BUS_STEP), .BUS_DONE(BUS_DONE), .BUS_RDATA(BUS_RDATA), .BUS_WDATA(BUS_WDATA),
    .MEM_WAIT_STATES(MEM_WAIT_STATES), .IO_WAIT_STATES(IO_WAIT_STATES), .CH0_COUNT(CH0_COUNT),
    .CH1_COUNT(CH1_COUNT), .DMA_IRQ(DMA_IRQ));
  dcd_bus_partner u_dcd_bus_partner (.clk(CLK), .bus_rd(BUS_RD), .bus_wr(BUS_WR), .bus_done(BUS_DONE),
    .bus_wdata(BUS_WDATA), .bus_rdata(BUS_RDATA), .serve(req[0]), .req_pin_n(pin_n), .wr_count(wr_count),
    .bad(bad));
  task tally_and_finish;
  begin
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge CLK);
    IO_ADDR = a;
    IO_WDATA = v;
    IO_WR = 1;
    @(negedge CLK);
    IO_WR = 0;
  end
  endtask
  // Read data is registered, so it is settled by the next falling edge
  task rc(input [7:0] a, input [7:0] e, input string nm);
  begin
    @(negedge CLK);
    IO_ADDR = a;
    IO_RD = 1;
    @(negedge CLK);
    IO_RD = 0;
    chk(IO_RDATA, e, nm);
  end
  endtask
  task load(input ch, input [15:0] n);
  begin
    @(negedge CLK);
    CH0_COUNT_IN = n;
    CH1_COUNT_IN = n;
    CH0_COUNT_LOAD = !ch;
    CH1_COUNT_LOAD = ch;
    @(negedge CLK);
    CH0_COUNT_LOAD = 0;
    CH1_COUNT_LOAD = 0;
  end
  endtask
  // Waits for the channel to run dry and the bus to be handed back, counting bus releases
  task drain(input ch);
    integer k;
    reg h;
  begin
    falls = 0;
    h = BUS_HOLD;
    for (k = 0; k < 2000 && !((ch ? CH1_COUNT : CH0_COUNT) === 16'h0000 && BUS_HOLD === 1'b0); k = k + 1)
    begin
      @(negedge CLK);
      if (h && !BUS_HOLD)
        falls = falls + 1;
      h = BUS_HOLD;
    end
    if (k == 2000)
    begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  endtask
  task run_mm(input [7:0] mode, input [15:0] n, input [15:0] f);
  begin
    keep = {8'h00, wr_count};
    load(0, n);
    wr(8'h31, mode);
    wr(8'h30, 8'h64);
    drain(0);
    chk(falls, f, "bus_releases");
    chk(wr_count - keep[7:0], n, "bytes");
    chk(bad, 8'h00, "data");
    rc(8'h30, 8'h35, "status");
    chk(DMA_IRQ, 1'b1, "irq");
  end
  endtask
  // A paced channel must sit still until its own request source asks
  task run_c1(input [2:0] sel, input [7:0] dc, input [4:0] rq);
  begin
    CH1_REQ_SEL = sel;
    load(1, 16'h0001);
    wr(8'h32, dc);
    wr(8'h30, 8'h9C);
    cyc(20);
    chk(CH1_COUNT, 16'h0001, "unpaced_count");
    req = rq;
    drain(1);
    req = 5'h00;
    rc(8'h30, 8'h3D, "status");
  end
  endtask
  initial
  begin
    cyc(4);
    RST = 0;
    rc(8'h30, 8'h30, "status");
    rc(8'h31, 8'h00, "mode");
    rc(8'h32, 8'hF0, "wait_ctl");
    rc(8'h33, 8'h00, "unmapped");
    chk(DMA_IRQ, 1'b0, "irq");
    // Twelve mode codes with burst tied to the source low bit, alongside every wait, sense and direction code
    for (i = 0; i < 16; i = i + 1)
    begin
      if (!(i[3] && i[1]))
      begin
        wr(8'h31, {2'h0, i[3:0], i[0], 1'b0});
        rc(8'h31, {2'h0, i[3:0], i[0], 1'b0}, "mode");
      end
      if (i < 4)
      begin
        wr(8'h32, {4{i[1:0]}});
        chk(MEM_WAIT_STATES, i, "mem_wait");
        chk(IO_WAIT_STATES, i + 1, "io_wait");
        rc(8'h32, {4{i[1:0]}}, "wait_ctl");
      end
    end
    wr(8'h30, 8'hF4);
    rc(8'h30, 8'h34, "status");
    chk(DMA_IRQ, 1'b1, "irq");
    wr(8'h30, 8'hC0);
    rc(8'h30, 8'h31, "status");
    wr(8'h30, 8'h24);
    chk(DMA_IRQ, 1'b1, "irq");
    run_mm(8'h02, 16'h0003, 16'h0001);
    run_mm(8'h00, 16'h0003, 16'h0003);
    // Non-maskable interrupt in mid-transfer freezes the channel until it is re-enabled
    load(0, 16'h0004);
    wr(8'h30, 8'h64);
    for (i = 0; i < 500 && CH0_COUNT !== 16'h0003; i = i + 1)
      cyc(1);
    chk(CH0_COUNT, 16'h0003, "count");
    if (CH0_COUNT !== 16'h0003)
      tally_and_finish;
    NMI_N = 0;
    cyc(3);
    NMI_N = 1;
    cyc(20);
    rc(8'h30, 8'h74, "status");
    keep = CH0_COUNT;
    wr(8'h30, 8'h35);
    cyc(30);
    chk(CH0_COUNT, keep, "held_count");
    rc(8'h30, 8'h74, "status");
    wr(8'h30, 8'h64);
    drain(0);
    rc(8'h30, 8'h35, "status");
    // Channel 0 with an I/O source waits for its pin request and ignores burst select
    CH0_REQ_SEL = 2'h0;
    load(0, 16'h0002);
    wr(8'h31, 8'h0E);
    wr(8'h32, 8'h00);
    wr(8'h30, 8'h64);
    cyc(20);
    chk(CH0_COUNT, 16'h0002, "unpaced_count");
    req = 5'h01;
    drain(0);
    req = 5'h00;
    chk(falls, 2, "bus_releases");
    chk(bad, 8'h00, "data");
    run_c1(3'h0, 8'h04, 5'h01);
    run_c1(3'h1, 8'h02, 5'h04);
    run_c1(3'h2, 8'h05, 5'h08);
    run_c1(3'h2, 8'h03, 5'h10);
    run_c1(3'h1, 8'h04, 5'h02);
    chk(bad, 8'h00, "data");
    tally_and_finish;
  end
endmodule
